/* File: fpalu_pkg.sv */
// Purpose: Shared constants and types for the fixed-point ALU slice
//          (subtract, add with carry, subtract with borrow, average, compares).
// Assumes: 40-bit data registers, fixed-point field in bits 39:8.
// Notes:   Register offsets and status bit positions are local choices.
package fpalu_pkg;

	localparam int FX_W  = 32;
	localparam int EXT_W = 8;
	localparam int REG_W = FX_W + EXT_W;
	localparam int N_PE  = 2;
	localparam int ADR_W = 8;

	// Register byte addresses
	localparam logic [ADR_W-1:0] ADDR_FIRST_MODE = 8'h00;
	localparam logic [ADR_W-1:0] ADDR_STAT_X     = 8'h04;
	localparam logic [ADR_W-1:0] ADDR_STAT_Y     = 8'h08;
	localparam logic [ADR_W-1:0] ADDR_STKY_X     = 8'h0C;
	localparam logic [ADR_W-1:0] ADDR_STKY_Y     = 8'h10;

	// Arithmetic status bit positions
	localparam int ST_ZERO    = 0;
	localparam int ST_OVF     = 1;
	localparam int ST_NEG     = 2;
	localparam int ST_CARRY   = 3;
	localparam int ST_SIGN    = 4;
	localparam int ST_INV     = 5;
	localparam int ST_FLOAT   = 10;
	localparam int ST_HIST_LO = 24;
	localparam int ST_HIST_HI = 31;

	// Sticky bit positions
	localparam int STK_UNDER  = 0;
	localparam int STK_FOVF   = 1;
	localparam int STK_XOVF   = 2;
	localparam int STK_INV    = 3;

	// First mode register bit positions
	localparam int MODE_TRUNC = 15;
	localparam int MODE_SAT   = 13;

	localparam logic [31:0] FIRST_MODE_RST = 32'h0000_0000;
	localparam logic [31:0] STAT_RST       = 32'h0000_0000;
	localparam logic [31:0] STKY_RST       = 32'h0000_0000;

	localparam logic [FX_W-1:0]  SAT_POS  = 32'h7FFF_FFFF;
	localparam logic [FX_W-1:0]  SAT_NEG  = 32'h8000_0000;
	localparam logic [EXT_W-1:0] EXT_ZERO = 8'h00;

	typedef enum logic [2:0] {
		OP_NOP   = 3'b000,
		OP_SUB   = 3'b001,
		OP_ADDC  = 3'b010,
		OP_SUBB  = 3'b011,
		OP_AVG   = 3'b100,
		OP_COMP  = 3'b101,
		OP_UNSIGNED_COMPARE_OP = 3'b110,
		OP_FCMP  = 3'b111
	} fpalu_op_t;

	typedef struct packed {
		logic      valid;
		fpalu_op_t op;
		logic      simd;
		logic      fcmp_greater;
	} fpalu_req_t;

	typedef struct packed {
		logic [REG_W-1:0] first;
		logic [REG_W-1:0] second;
	} fpalu_opnd_t;

	typedef struct packed {
		logic             we;
		logic [REG_W-1:0] data;
	} fpalu_res_t;

endpackage : fpalu_pkg

/* File: fpalu_adder.sv */
// Purpose: 32-bit adder exposing the carries of its two top stages.
// Assumes: Subtraction is done by the caller inverting the second operand.
// Notes:   Split at bit 31 so the carry into the top stage is visible.
`timescale 1ns/100ps
`default_nettype none
module fpalu_adder
	import fpalu_pkg::*;
(
	input  wire logic [FX_W-1:0] a,
	input  wire logic [FX_W-1:0] b,
	input  wire logic            cin,
	output var  logic [FX_W-1:0] sum,
	output var  logic            carry_top,
	output var  logic            carry_pre
);
	logic [FX_W-1:0] low;
	logic [1:0]      high;

	always_comb begin
		low       = {1'b0, a[FX_W-2:0]} + {1'b0, b[FX_W-2:0]} + {{(FX_W-1){1'b0}}, cin};
		carry_pre = low[FX_W-1];
		high      = {1'b0, a[FX_W-1]} + {1'b0, b[FX_W-1]} + {1'b0, carry_pre};
		carry_top = high[1];
		sum       = {high[0], low[FX_W-2:0]};
	end

endmodule : fpalu_adder
`default_nettype wire

/* File: fpalu_cmp.sv */
// Purpose: Signed or unsigned magnitude compare of two fixed-point fields.
// Assumes: Purely combinational; the caller registers the outcome.
// Notes:   Greater is neither equal nor less.
`timescale 1ns/100ps
`default_nettype none
module fpalu_cmp
	import fpalu_pkg::*;
(
	input  wire logic [FX_W-1:0] a,
	input  wire logic [FX_W-1:0] b,
	input  wire logic            is_unsigned,
	output var  logic            equal,
	output var  logic            less,
	output var  logic            greater
);
	always_comb begin
		equal   = (a == b);
		less    = is_unsigned ? (a < b) : ($signed(a) < $signed(b));
		greater = ~equal & ~less;
	end

endmodule : fpalu_cmp
`default_nettype wire

/* File: fpalu_top.sv */
// Purpose: Fixed-point ALU slice for two processing elements, with status,
//          sticky and first mode registers on a plain register port.
// Assumes: One request per cycle; results and flags appear one cycle later.
// Notes:   Processing element y acts only when the request is marked SIMD.
`timescale 1ns/100ps
`default_nettype none
module fpalu_top
	import fpalu_pkg::*;
(
	input  wire logic                        clock,
	input  wire logic                        srst,
	input  wire fpalu_pkg::fpalu_req_t       req,
	input  wire fpalu_pkg::fpalu_opnd_t      opnd_x,
	input  wire fpalu_pkg::fpalu_opnd_t      opnd_y,
	output var  fpalu_pkg::fpalu_res_t       res_x,
	output var  fpalu_pkg::fpalu_res_t       res_y,
	output var  logic [31:0]                 status_x,
	output var  logic [31:0]                 status_y,
	output var  logic [31:0]                 first_mode_reg,
	input  wire logic [fpalu_pkg::ADR_W-1:0] reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_we,
	input  wire logic                        reg_re,
	output var  logic [31:0]                 reg_rdata
);
	import fpalu_pkg::*;

	// Per-element state, index 0 is element x, index 1 is element y
	logic [31:0]      stat    [N_PE];
	logic [31:0]      stky    [N_PE];
	logic [31:0]      next_stat [N_PE];
	logic [31:0]      next_stky [N_PE];
	logic [FX_W-1:0]  next_fx [N_PE];
	logic             pe_en   [N_PE];
	logic             wr_dest [N_PE];
	logic             sw_stat_we [N_PE];
	logic             sw_stky_we [N_PE];
	fpalu_opnd_t      opnd    [N_PE];
	fpalu_res_t       res     [N_PE];

	logic sat_en;
	logic trunc_en;
	logic is_arith;
	logic is_addsub;
	logic is_cmp;

	assign opnd[0]  = opnd_x;
	assign opnd[1]  = opnd_y;
	assign status_x = stat[0];
	assign status_y = stat[1];
	assign res_x    = res[0];
	assign res_y    = res[1];

	assign sat_en   = first_mode_reg[MODE_SAT];
	assign trunc_en = first_mode_reg[MODE_TRUNC];

	// Operation classes
	always_comb begin
		is_addsub = 1'b0;
		is_arith  = 1'b0;
		is_cmp    = 1'b0;
		unique case (req.op)
			OP_SUB, OP_ADDC, OP_SUBB: begin
				is_addsub = 1'b1;
				is_arith  = 1'b1;
			end
			OP_AVG: begin
				is_arith  = 1'b1;
			end
			OP_COMP, OP_UNSIGNED_COMPARE_OP: begin
				is_cmp    = 1'b1;
			end
			OP_NOP, OP_FCMP: begin
				is_arith  = 1'b0;
			end
		endcase
	end

	// Software write strobes for the per-element registers
	assign sw_stat_we[0] = reg_we && (reg_addr == ADDR_STAT_X);
	assign sw_stat_we[1] = reg_we && (reg_addr == ADDR_STAT_Y);
	assign sw_stky_we[0] = reg_we && (reg_addr == ADDR_STKY_X);
	assign sw_stky_we[1] = reg_we && (reg_addr == ADDR_STKY_Y);

	// Element y joins in only for SIMD requests
	assign pe_en[0] = req.valid;
	assign pe_en[1] = req.valid && req.simd;

	for (genvar p = 0; p < N_PE; p++) begin : g_pe
		logic [FX_W-1:0] fx_a;
		logic [FX_W-1:0] fx_b;
		logic [FX_W-1:0] add_b;
		logic            add_cin;
		logic [FX_W-1:0] sum;
		logic            c_top;
		logic            c_pre;
		logic            ovf;
		logic            avg_sign;
		logic [FX_W-1:0] avg_half;
		logic [FX_W-1:0] avg_res;
		logic            cmp_eq;
		logic            cmp_lt;
		logic            cmp_gt;
		logic            hist_in;

		assign fx_a = opnd[p].first[REG_W-1:EXT_W];
		assign fx_b = opnd[p].second[REG_W-1:EXT_W];

		// Adder operand selection; borrow is one minus carry, so a + ~b + carry
		always_comb begin
			add_b   = fx_b;
			add_cin = 1'b0;
			unique case (req.op)
				OP_SUB: begin
					add_b   = ~fx_b;
					add_cin = 1'b1;
				end
				OP_ADDC: begin
					add_cin = stat[p][ST_CARRY];
				end
				OP_SUBB: begin
					add_b   = ~fx_b;
					add_cin = stat[p][ST_CARRY];
				end
				OP_NOP, OP_AVG, OP_COMP, OP_UNSIGNED_COMPARE_OP, OP_FCMP: begin
					add_cin = 1'b0;
				end
			endcase
		end

		fpalu_adder u_adder (
			.a         (fx_a),
			.b         (add_b),
			.cin       (add_cin),
			.sum       (sum),
			.carry_top (c_top),
			.carry_pre (c_pre)
		);

		fpalu_cmp u_cmp (
			.a           (fx_a),
			.b           (fx_b),
			.is_unsigned (req.op == OP_UNSIGNED_COMPARE_OP),
			.equal       (cmp_eq),
			.less        (cmp_lt),
			.greater     (cmp_gt)
		);

		assign ovf = c_top ^ c_pre;

		// Average: 33-bit signed sum halved, then rounded to nearest even
		always_comb begin
			avg_sign = fx_a[FX_W-1] ^ fx_b[FX_W-1] ^ c_top;
			avg_half = {avg_sign, sum[FX_W-1:1]};
			if (!trunc_en && sum[0] && sum[1]) begin
				avg_res = avg_half + {{(FX_W-1){1'b0}}, 1'b1};
			end else begin
				avg_res = avg_half;
			end
		end

		// Destination fixed-point value
		always_comb begin
			if (req.op == OP_AVG) begin
				next_fx[p] = avg_res;
			end else if (sat_en && ovf) begin
				next_fx[p] = c_top ? SAT_NEG : SAT_POS;
			end else begin
				next_fx[p] = sum;
			end
		end

		assign wr_dest[p] = pe_en[p] && is_arith;
		assign hist_in    = (req.op == OP_FCMP) ? req.fcmp_greater : cmp_gt;

		// Next status word for this element
		always_comb begin
			next_stat[p] = stat[p];
			if (pe_en[p] && (is_arith || is_cmp)) begin
				next_stat[p][ST_SIGN]  = 1'b0;
				next_stat[p][ST_INV]   = 1'b0;
				next_stat[p][ST_FLOAT] = 1'b0;
			end
			if (pe_en[p] && is_arith) begin
				next_stat[p][ST_ZERO]  = (next_fx[p] == '0);
				next_stat[p][ST_NEG]   = next_fx[p][FX_W-1];
				next_stat[p][ST_CARRY] = c_top;
				next_stat[p][ST_OVF]   = is_addsub ? ovf : 1'b0;
			end
			if (pe_en[p] && is_cmp) begin
				next_stat[p][ST_ZERO]  = cmp_eq;
				next_stat[p][ST_NEG]   = cmp_lt;
				next_stat[p][ST_OVF]   = 1'b0;
				next_stat[p][ST_CARRY] = 1'b0;
			end
			// History shifts only on compares, dropping its lowest bit
			if (pe_en[p] && (is_cmp || req.op == OP_FCMP)) begin
				next_stat[p][ST_HIST_HI:ST_HIST_LO] =
					{hist_in, stat[p][ST_HIST_HI:ST_HIST_LO+1]};
			end
		end

		// Sticky word: hardware set wins over a software clear
		always_comb begin
			next_stky[p] = sw_stky_we[p] ? reg_wdata : stky[p];
			if (pe_en[p] && is_addsub && ovf) begin
				next_stky[p][STK_XOVF] = 1'b1;
			end
		end

		// Status register: an executing operation takes precedence over software
		always_ff @(posedge clock) begin
			if (srst) begin
				stat[p] <= STAT_RST;
			end else if (pe_en[p] && is_arith) begin
				stat[p] <= next_stat[p];
			end else if (pe_en[p] && (is_cmp || req.op == OP_FCMP)) begin
				stat[p] <= next_stat[p];
			end else if (sw_stat_we[p]) begin
				stat[p] <= reg_wdata;
			end
		end

		always_ff @(posedge clock) begin
			if (srst) begin
				stky[p] <= STKY_RST;
			end else begin
				stky[p] <= next_stky[p];
			end
		end

		// Destination write back with cleared extension field
		always_ff @(posedge clock) begin
			if (srst) begin
				res[p] <= '0;
			end else begin
				res[p].we <= wr_dest[p];
				if (wr_dest[p]) begin
					res[p].data <= {next_fx[p], EXT_ZERO};
				end
			end
		end
	end

	// First mode register steers saturation and rounding
	always_ff @(posedge clock) begin
		if (srst) begin
			first_mode_reg <= FIRST_MODE_RST;
		end else if (reg_we && (reg_addr == ADDR_FIRST_MODE)) begin
			first_mode_reg <= reg_wdata;
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_re) begin
			unique case (reg_addr)
				ADDR_FIRST_MODE: reg_rdata <= first_mode_reg;
				ADDR_STAT_X:     reg_rdata <= stat[0];
				ADDR_STAT_Y:     reg_rdata <= stat[1];
				ADDR_STKY_X:     reg_rdata <= stky[0];
				ADDR_STKY_Y:     reg_rdata <= stky[1];
				default:         reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule : fpalu_top
`default_nettype wire

/* File: fpalu_chk.sv */
// Purpose: Port assertions for the fixed-point ALU slice.
// Assumes: Results and flags land one cycle after the request.
// Notes:   Watches element x closely; y only for the SIMD gate.
`timescale 1ns/100ps
`default_nettype none
module fpalu_chk
	import fpalu_pkg::*;
(
	input wire logic                  clock,
	input wire logic                  srst,
	input wire fpalu_pkg::fpalu_req_t req,
	input wire fpalu_pkg::fpalu_res_t res_x,
	input wire fpalu_pkg::fpalu_res_t res_y,
	input wire logic [31:0]           status_x
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_arith;
		req.valid && req.op inside {OP_SUB, OP_ADDC, OP_SUBB, OP_AVG};
	endsequence
	sequence s_cmp;
		req.valid && req.op inside {OP_COMP, OP_UNSIGNED_COMPARE_OP};
	endsequence
	result_ext_a: assert property (s_arith |=> res_x.we && res_x.data[7:0] == EXT_ZERO)
		else $error("result missing or extension set");
	cmp_nowrite_a: assert property (s_cmp |=> !res_x.we)
		else $error("compare wrote a result");
	zero_flag_a:
		assert property (res_x.we |-> status_x[ST_ZERO] == (res_x.data[39:8] == 32'h0))
		else $error("zero flag wrong");
	neg_flag_a: assert property (res_x.we |-> status_x[ST_NEG] == res_x.data[39])
		else $error("negative flag wrong");
	hist_hold_a: assert property (s_arith |=> $stable(status_x[31:24]))
		else $error("history changed");
	hist_shift_a: assert property (s_cmp |=> status_x[30:24] == $past(status_x[31:25]))
		else $error("history not shifted");
	hist_top_a:
		assert property (s_cmp |=> status_x[31] == !(status_x[ST_ZERO] || status_x[ST_NEG]))
		else $error("history top bit wrong");
	float_clr_a: assert property (s_arith |=> !status_x[ST_FLOAT])
		else $error("float flag left set");
	cmp_clear_a:
		assert property (s_cmp |=> status_x[5:4] == 2'h0 && !status_x[ST_CARRY] && !status_x[ST_OVF])
		else $error("compare left flags set");
	simd_gate_a: assert property (req.valid && !req.simd |=> !res_y.we)
		else $error("element y wrote without SIMD");
endmodule : fpalu_chk
bind fpalu_top fpalu_chk fpalu_chk_i (.clock(clock), .srst(srst), .req(req), .res_x(res_x),
	.res_y(res_y), .status_x(status_x));
`default_nettype wire

/* File: fpalu_rf.sv */
// Purpose: Register-file end keeping each element's last written result.
// Assumes: Writes arrive as one-cycle strobes.
// Notes:   Extension bits kept so they can be inspected.
`timescale 1ns/100ps
`default_nettype none
module fpalu_rf
	import fpalu_pkg::*;
(
	input  wire logic                    clock,
	input  wire fpalu_pkg::fpalu_res_t   res_x,
	input  wire fpalu_pkg::fpalu_res_t   res_y,
	output var  logic [fpalu_pkg::REG_W-1:0] dest_x,
	output var  logic [fpalu_pkg::REG_W-1:0] dest_y
);
	always_ff @(posedge clock) begin
		if (res_x.we) begin
			dest_x <= res_x.data;
		end
		if (res_y.we) begin
			dest_y <= res_y.data;
		end
	end
endmodule : fpalu_rf
`default_nettype wire

/* File: fpalu_top_tb.sv */
// Purpose: Random and corner checks of the fixed-point ALU slice.
// Assumes: Results one cycle after the request edge.
// Notes:   Expected state kept in m_st, m_sk and m_mode.
`timescale 1ns/100ps
`default_nettype none
module fpalu_top_tb;
	import fpalu_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	fpalu_req_t req = '0;
	fpalu_req_t p_req = '0;
	fpalu_opnd_t opnd_x = '0;
	fpalu_opnd_t opnd_y = '0;
	fpalu_opnd_t p_op [2] = '{'0, '0};
	fpalu_res_t res_x, res_y;
	logic [31:0] status_x, status_y, first_mode_reg, reg_rdata;
	logic [31:0] reg_wdata = '0;
	logic [31:0] m_st [2] = '{'0, '0};
	logic [31:0] m_sk [2] = '{'0, '0};
	logic [31:0] m_mode = '0;
	logic [ADR_W-1:0] reg_addr = '0;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [REG_W-1:0] dest_x, dest_y, m_last, m_last_y;
	int fails = 0;
	int samples_checked = 0;
	int unsigned seed_val;

	always #2.5 clock = ~clock;

	fpalu_top fpalu_top_i (.clock(clock), .srst(srst), .req(req), .opnd_x(opnd_x),
		.opnd_y(opnd_y), .res_x(res_x), .res_y(res_y), .status_x(status_x),
		.status_y(status_y), .first_mode_reg(first_mode_reg), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
	fpalu_rf fpalu_rf_i (.clock(clock), .res_x(res_x), .res_y(res_y), .dest_x(dest_x),
		.dest_y(dest_y));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		if (fails == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_re <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd

	function automatic logic [31:0] rv();
		case ($urandom % 7)
			0: return 32'h7FFF_FFFF;
			1: return 32'h8000_0000;
			2: return 32'h0;
			3: return 32'hFFFF_FFFF;
			4: return 32'h1;
			default: return $urandom;
		endcase
	endfunction : rv

	function automatic fpalu_opnd_t rop();
		return fpalu_opnd_t'({rv(), 8'($urandom), rv(), 8'($urandom)});
	endfunction : rop

	// Advances the model for one element and returns {we, data}
	function automatic logic [40:0] calc(input int e, input fpalu_req_t q, input fpalu_opnd_t o);
		logic [31:0] a, b, r, s;
		logic [32:0] u;
		logic v, lo;
		a = o.first[39:8];
		b = o.second[39:8];
		s = m_st[e];
		if (!q.valid || q.op == OP_NOP || (e == 1 && !q.simd)) return '0;
		if (q.op == OP_FCMP) begin
			m_st[e][31:24] = {q.fcmp_greater, s[31:25]};
			return '0;
		end
		s[ST_FLOAT] = 1'b0;
		s[5:0] = 6'h00;
		if (q.op == OP_COMP || q.op == OP_UNSIGNED_COMPARE_OP) begin
			lo = (q.op == OP_COMP) ? ($signed(a) < $signed(b)) : (a < b);
			s[ST_ZERO] = (a == b);
			s[ST_NEG] = lo;
			s[31:24] = {a != b && !lo, s[31:25]};
			m_st[e] = s;
			return '0;
		end
		v = 1'b0;
		if (q.op == OP_AVG) begin
			u = {a[31], a} + {b[31], b};
			r = u[32:1];
			if (!m_mode[MODE_TRUNC] && u[0] && r[0]) r = r + 32'h1;
			u = {1'b0, a} + {1'b0, b};
		end else begin
			if (q.op != OP_ADDC) b = ~b;
			u = {1'b0, a} + {1'b0, b} + ((q.op == OP_SUB) ? 33'h1 : 33'(m_st[e][ST_CARRY]));
			v = u[32] ^ a[31] ^ b[31] ^ u[31];
			r = (v && m_mode[MODE_SAT]) ? (u[31] ? SAT_POS : SAT_NEG) : u[31:0];
			if (v) m_sk[e][STK_XOVF] = 1'b1;
		end
		s[ST_ZERO] = (r == 32'h0);
		s[ST_NEG] = r[31];
		s[ST_OVF] = v;
		s[ST_CARRY] = u[32];
		m_st[e] = s;
		return {1'b1, r, EXT_ZERO};
	endfunction : calc

	// Drives one request and checks the one taken at the same edge
	task automatic step(input fpalu_req_t q, input fpalu_opnd_t ox, input fpalu_opnd_t oy);
		logic [40:0] ex, ey;
		@(posedge clock);
		req <= q;
		opnd_x <= ox;
		opnd_y <= oy;
		#1;
		ex = calc(0, p_req, p_op[0]);
		ey = calc(1, p_req, p_op[1]);
		if (ex[40]) m_last = ex[39:0];
		if (ey[40]) m_last_y = ey[39:0];
		chk({res_x.we, ex[40] ? res_x.data : 40'h0}, ex);
		chk({res_y.we, ey[40] ? res_y.data : 40'h0}, ey);
		chk(status_x, m_st[0]);
		chk(status_y, m_st[1]);
		chk(first_mode_reg, m_mode);
		p_req = q;
		p_op[0] = ox;
		p_op[1] = oy;
	endtask : step

	initial begin
		seed_val = $urandom(56);
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		#1;
		chk(status_x, STAT_RST);
		rd(8'h20, 32'h0);
		for (int i = 0; i < 640; i++) begin
			if (i % 40 == 0) begin
				step('0, '0, '0);
				rd(ADDR_STAT_X, m_st[0]);
				rd(ADDR_STKY_X, m_sk[0]);
				rd(ADDR_STKY_Y, m_sk[1]);
				m_mode = 32'h0;
				m_mode[MODE_SAT] = 1'((i / 40) % 2);
				m_mode[MODE_TRUNC] = 1'((i / 80) % 2);
				wr(ADDR_FIRST_MODE, m_mode);
				rd(ADDR_FIRST_MODE, m_mode);
			end
			step(fpalu_req_t'(6'($urandom)), rop(), rop());
		end
		step('0, '0, '0);
		repeat (2) @(posedge clock);
		chk(dest_x, m_last);
		chk(dest_y, m_last_y);
		report_and_stop();
	end

	initial begin
		#50us;
		fails++;
		report_and_stop();
	end
endmodule : fpalu_top_tb
`default_nettype wire
